/* File: src/scs_chan_status_regs.v */
// scs_chan_status_regs.v: three read-only channel-status registers of the
// receiver plus the status update flag.
// assumes recovered subframe strobes and a read port from the serial
// control interface, all synchronous to clk.
//
// Function
// - source number bits 19:16 to reg bits 3:0
// - first subframe channel bits 21:20 to 5:4
// - second subframe channel bits 23:22 to 7:6
// - rate code bits 27:24 raw in 3:0
// - clock accuracy bits 29:28 into 5:4
// - accuracy code 11 flags rate mismatch
// - capture status from first channel only
// - update flag set on store, cleared by a read of a mapped register, store wins
`timescale 1ns/1ps
`include "scs_chan_status_map.vh"

module scs_chan_status_regs (
   clk,
   reset_n,
   subframeStrobe,
   subframeIsFirst,
   blockStart,
   channelBit,
   regAddr,
   regRead,
   regReadData,
   statusUpdateFlag,
   rateMismatch
);
   input                      clk;
   input                      reset_n;
   input                      subframeStrobe;
   input                      subframeIsFirst;
   input                      blockStart;
   input                      channelBit;
   input  [`SCS_ADDR_W-1:0]   regAddr;
   input                      regRead;
   output [7:0]               regReadData;
   output                     statusUpdateFlag;
   output                     rateMismatch;

   reg    [7:0]               regReadData;
   reg                        statusUpdateFlag;
   reg                        rateMismatch;
   reg    [7:0]               sourceChannelStatus;
   reg    [7:0]               rateAccuracyStatus;
   reg    [7:0]               wordLengthStatus;
   reg    [7:0]               next_sourceChannelStatus;
   reg    [7:0]               next_rateAccuracyStatus;
   reg    [7:0]               next_wordLengthStatus;
   reg                        next_rateMismatch;
   reg                        next_statusUpdateFlag;
   reg    [7:0]               next_readData;
   wire   [23:0]              blockBits;
   wire                       blockDone;
   wire                       csRead;
   wire   [3:0]               sourceNibble;
   wire   [3:0]               firstChanNibble;
   wire   [3:0]               secondChanNibble;
   wire   [3:0]               rateNibble;
   wire   [3:0]               accuracyNibble;
   wire   [3:0]               lengthNibble;
   wire   [3:0]               origRateNibble;
   wire   [3:0]               sourceNumber;
   wire   [1:0]               firstSubframeChannel;
   wire   [1:0]               secondSubframeChannel;
   wire   [3:0]               indicatedRateCode;
   wire   [1:0]               clockAccuracyLevel;
   wire                       maxSampleLength;
   wire   [2:0]               sampleLengthCode;
   wire   [3:0]               originalRateCode;

   // four status bits starting at channel-status bit csBit;
   // blockBits[0] holds channel-status bit 16
   function [3:0] fieldAt;
      input [23:0] bits;
      input integer csBit;
      reg   [23:0] shifted;
      begin
         shifted = bits >> (csBit - `SCS_CS_FIRST_BIT);
         fieldAt = shifted[3:0];
      end
   endfunction

   function isStatusAddr;
      input [`SCS_ADDR_W-1:0] addr;
      begin
         isStatusAddr = (addr == `SCS_OFF_SOURCE) |
                        (addr == `SCS_OFF_RATE) |
                        (addr == `SCS_OFF_WORDLEN);
      end
   endfunction

   scs_cs_collect u_collect (
      .clk             (clk),
      .reset_n         (reset_n),
      .subframeStrobe  (subframeStrobe),
      .subframeIsFirst (subframeIsFirst),
      .blockStart      (blockStart),
      .channelBit      (channelBit),
      .blockBits       (blockBits),
      .blockDone       (blockDone)
   );

   assign sourceNibble     = fieldAt(blockBits, `SCS_CS_SOURCE_BIT);
   assign firstChanNibble  = fieldAt(blockBits, `SCS_CS_FIRST_CHAN_BIT);
   assign secondChanNibble = fieldAt(blockBits, `SCS_CS_SECOND_CHAN_BIT);
   assign rateNibble       = fieldAt(blockBits, `SCS_CS_RATE_BIT);
   assign accuracyNibble   = fieldAt(blockBits, `SCS_CS_ACCURACY_BIT);
   assign lengthNibble     = fieldAt(blockBits, `SCS_CS_LENGTH_BIT);
   assign origRateNibble   = fieldAt(blockBits, `SCS_CS_ORIG_RATE_BIT);

   assign sourceNumber          = sourceNibble;
   assign firstSubframeChannel  = firstChanNibble[1:0];
   assign secondSubframeChannel = secondChanNibble[1:0];
   assign indicatedRateCode     = rateNibble;
   assign clockAccuracyLevel    = accuracyNibble[1:0];
   // fields kept raw: the source sets them to its real length
   assign maxSampleLength       = lengthNibble[0];
   assign sampleLengthCode      = lengthNibble[3:1];
   assign originalRateCode      = origRateNibble;

   // only a read of a mapped register acknowledges the update
   assign csRead = regRead & isStatusAddr(regAddr);

   // registers only move when a whole first-channel block is
   always @* begin
      next_sourceChannelStatus = sourceChannelStatus;
      next_rateAccuracyStatus  = rateAccuracyStatus;
      next_wordLengthStatus    = wordLengthStatus;
      next_rateMismatch        = rateMismatch;
      if (blockDone) begin
         next_sourceChannelStatus = {secondSubframeChannel,
                                     firstSubframeChannel,
                                     sourceNumber};
         next_rateAccuracyStatus  = {2'h0,
                                     clockAccuracyLevel,
                                     indicatedRateCode};
         next_wordLengthStatus    = {originalRateCode,
                                     sampleLengthCode,
                                     maxSampleLength};
         next_rateMismatch        = (clockAccuracyLevel ==
                                     `SCS_ACCURACY_MISMATCH);
      end
   end

   // a store in the same cycle as a read wins, so no update is lost
   always @* begin
      next_statusUpdateFlag = statusUpdateFlag;
      if (blockDone)
         next_statusUpdateFlag = 1'b1;
      else if (csRead)
         next_statusUpdateFlag = 1'b0;
   end

   // unmapped addresses read as zero and leave the flag alone
   always @* begin
      next_readData = regReadData;
      if (regRead) begin
         if (isStatusAddr(regAddr)) begin
            case (regAddr)
               `SCS_OFF_SOURCE:  next_readData = sourceChannelStatus;
               `SCS_OFF_RATE:    next_readData = rateAccuracyStatus;
               `SCS_OFF_WORDLEN: next_readData = wordLengthStatus;
               default:          next_readData = 8'h00;
            endcase
         end else begin
            next_readData = 8'h00;
         end
      end
   end

   always @(posedge clk) begin
      if (!reset_n)
         sourceChannelStatus <= `SCS_REG_RESET;
      else
         sourceChannelStatus <= next_sourceChannelStatus;
   end

   always @(posedge clk) begin
      if (!reset_n)
         rateAccuracyStatus <= `SCS_REG_RESET;
      else
         rateAccuracyStatus <= next_rateAccuracyStatus;
   end

   always @(posedge clk) begin
      if (!reset_n)
         wordLengthStatus <= `SCS_REG_RESET;
      else
         wordLengthStatus <= next_wordLengthStatus;
   end

   always @(posedge clk) begin
      if (!reset_n)
         rateMismatch <= 1'b0;
      else
         rateMismatch <= next_rateMismatch;
   end

   always @(posedge clk) begin
      if (!reset_n)
         statusUpdateFlag <= 1'b0;
      else
         statusUpdateFlag <= next_statusUpdateFlag;
   end

   // read data holds between reads so a slow host can fetch it late
   always @(posedge clk) begin
      if (!reset_n)
         regReadData <= 8'h00;
      else
         regReadData <= next_readData;
   end
endmodule // scs_chan_status_regs

/* File: src/scs_chan_status_map.vh */
// scs_chan_status_map.vh: offsets, field positions and reset values of the
// receiver channel-status registers.
// assumes inclusion by the register bank and its bit collector only.
`ifndef SCS_CHAN_STATUS_MAP_VH
`define SCS_CHAN_STATUS_MAP_VH

`define SCS_ADDR_W            7
`define SCS_OFF_SOURCE        7'h2e
`define SCS_OFF_RATE          7'h2f
`define SCS_OFF_WORDLEN       7'h30

`define SCS_CS_FIRST_BIT      16
`define SCS_CS_LAST_BIT       39
`define SCS_CS_BLOCK_FRAMES   192
`define SCS_FRAME_CNT_W       8

`define SCS_SOURCE_NUMBER_LSB 0
`define SCS_FIRST_CHAN_LSB    4
`define SCS_SECOND_CHAN_LSB   6
`define SCS_RATE_CODE_LSB     0
`define SCS_ACCURACY_LSB      4
`define SCS_MAX_LENGTH_LSB    0
`define SCS_LENGTH_CODE_LSB   1
`define SCS_ORIG_RATE_LSB     4

`define SCS_CS_SOURCE_BIT     16
`define SCS_CS_FIRST_CHAN_BIT 20
`define SCS_CS_SECOND_CHAN_BIT 22
`define SCS_CS_RATE_BIT       24
`define SCS_CS_ACCURACY_BIT   28
`define SCS_CS_LENGTH_BIT     32
`define SCS_CS_ORIG_RATE_BIT  36

`define SCS_ACCURACY_MISMATCH 2'h3
`define SCS_REG_RESET         8'h00

`endif

/* File: src/scs_cs_collect.v */
// scs_cs_collect.v: gathers channel-status bits 16..39 of the first subframe
// over one 192-frame block and pulses when a block whose start was seen ends.
// assumes one channel bit per subframe strobe, block start flagged on frame 0.
`timescale 1ns/1ps
`include "scs_chan_status_map.vh"

module scs_cs_collect (
   clk,
   reset_n,
   subframeStrobe,
   subframeIsFirst,
   blockStart,
   channelBit,
   blockBits,
   blockDone
);
   input         clk;
   input         reset_n;
   input         subframeStrobe;
   input         subframeIsFirst;
   input         blockStart;
   input         channelBit;
   output [23:0] blockBits;
   output        blockDone;

   reg    [23:0] blockBits;
   reg           blockDone;
   reg    [23:0] shiftBits;
   reg    [`SCS_FRAME_CNT_W-1:0] frameIdx;
   reg           inBlock;

   wire          firstTake = subframeStrobe & subframeIsFirst;
   wire   [`SCS_FRAME_CNT_W-1:0] idx = blockStart ?
                                  {`SCS_FRAME_CNT_W{1'b0}} : frameIdx;

   always @(posedge clk) begin
      if (!reset_n) begin
         blockBits <= 24'h0000;
         blockDone <= 1'b0;
         shiftBits <= 24'h0000;
         frameIdx  <= {`SCS_FRAME_CNT_W{1'b0}};
         inBlock   <= 1'b0;
      end else begin
         blockDone <= 1'b0;
         if (firstTake) begin
            if (blockStart)
               inBlock <= 1'b1;
            if (idx >= `SCS_CS_FIRST_BIT && idx <= `SCS_CS_LAST_BIT)
               shiftBits <= {channelBit, shiftBits[23:1]};
            // a block is only published if its start was seen
            if (idx == `SCS_CS_BLOCK_FRAMES - 1) begin
               frameIdx <= {`SCS_FRAME_CNT_W{1'b0}};
               if (inBlock | blockStart) begin
                  blockBits <= shiftBits;
                  blockDone <= 1'b1;
               end
               inBlock <= 1'b0;
            end else begin
               frameIdx <= idx + 1'b1;
            end
         end
      end
   end
endmodule // scs_cs_collect

/* File: tb/scs_source_model.sv */
// source model: one 192-frame block per go, subframe B carries ~A in frames 16..39, equals A elsewhere
// assumes go is seen at a rising edge while idle
`timescale 1ns/1ps
module scs_source_model (input wire logic clk, go, noStart,
   input wire logic [23:0] a, output logic stb, first, blk, cb, busy);
   initial begin
      {stb, first, blk, cb, busy} = 5'h0;
      forever begin
         @(posedge clk iff go) busy = 1'b1;
         for (int f = 0; f < 384; f++) begin
            @(negedge clk);
            {stb, first, blk} = {1'b1, !f[0], f < 2 && !noStart};
            cb = (f < 32 || f > 79) ? f[1] : a[f/2-16] ^ f[0];
            @(negedge clk);
            // an idle line never repeats the last bit
            {stb, cb} = {1'b0, !cb};
         end
         busy = 1'b0;
      end
   end
endmodule // scs_source_model

/* File: tb/scs_chan_status_regs_monitor.sv */
// assertions on the status bank ports
// assumes one clk domain, synchronous reset_n
`timescale 1ns/1ps
module scs_chan_status_regs_monitor (input wire logic clk, reset_n,
   input wire logic subframeStrobe, subframeIsFirst, blockStart, channelBit,
   input wire logic [6:0] regAddr, input wire logic regRead,
   input wire logic [7:0] regReadData,
   input wire logic statusUpdateFlag, rateMismatch);
   default clocking dc @(posedge clk); endclocking
   default disable iff (!reset_n);
   wire rdMap = regRead && regAddr >= 7'h2e && regAddr <= 7'h30;
   // high in the cycle in which a block may be stored
   logic prevTake = 1'b0;
   always @(posedge clk) prevTake <= subframeStrobe && subframeIsFirst;
   sequence hostRead; rdMap && !prevTake; endsequence
   reset_zero_a: assert property (disable iff (1'b0) !reset_n
      |=> regReadData == 8'h00 && !statusUpdateFlag && !rateMismatch)
      else $error("reset");
   flag_clear_a: assert property (hostRead |=> !statusUpdateFlag)
      else $error("flag kept");
   flag_hold_a: assert property (statusUpdateFlag && !rdMap
      |=> statusUpdateFlag) else $error("flag lost");
   flag_cause_a: assert property ($rose(statusUpdateFlag)
      |-> $past(prevTake)) else $error("flag cause");
   code_cause_a: assert property ($changed(rateMismatch)
      |-> $past(prevTake)) else $error("code cause");
   rate_read_a: assert property (regRead && regAddr == 7'h2f
      && !prevTake |=> regReadData[7:6] == 2'b00 &&
      (regReadData[5:4] == 2'b11) == rateMismatch) else $error("rate");
   hole_read_a: assert property (regRead && !rdMap && !prevTake
      |=> regReadData == 8'h00 && $stable(statusUpdateFlag))
      else $error("hole");
   data_hold_a: assert property (!regRead |=> $stable(regReadData))
      else $error("data moved");
   b_ignored_a: assert property (subframeStrobe && !subframeIsFirst
      && !regRead |=> $stable(statusUpdateFlag) && $stable(rateMismatch))
      else $error("B used");
endmodule // scs_chan_status_regs_monitor
bind scs_chan_status_regs scs_chan_status_regs_monitor u_mon (.*);

/* File: tb/scs_chan_status_regs_tb_top.sv */
// bench for the channel-status register bank
// assumes source model and monitor are compiled first
`timescale 1ns/1ps
module scs_chan_status_regs_tb_top;
   logic clk = 1'b0, reset_n = 1'b0, go = 1'b0, regRead = 1'b0;
   logic noStart = 1'b0;
   logic [6:0] regAddr = 7'h00;
   logic [23:0] a = 24'h0;
   wire stb, first, blk, cb, busy, statusUpdateFlag, rateMismatch;
   wire [7:0] regReadData;
   int miscompares = 0, n_checks = 0, cycles = 0;
   always #25 clk = ~clk;
   scs_source_model src (.clk, .go, .noStart, .a, .stb, .first, .blk, .cb,
      .busy);
   scs_chan_status_regs DUT (.clk, .reset_n, .subframeStrobe(stb),
      .subframeIsFirst(first), .blockStart(blk), .channelBit(cb), .regAddr,
      .regRead, .regReadData, .statusUpdateFlag, .rateMismatch);
   task automatic give_verdict();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      miscompares += (got !== exp);
      if (got !== exp)
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
   endtask
   task automatic rd(input logic [6:0] ad, input logic [7:0] exp);
      @(negedge clk);
      {regAddr, regRead} = {ad, 1'b1};
      @(negedge clk);
      regRead = 1'b0;
      chk(regReadData, exp);
   endtask
   task automatic t_block(input logic [3:0] k);
      a = {8'hA5 ^ {k, k}, 2'b11, k[1:0], 4'h6 ^ k, k[1:0], ~k[1:0], k};
      go = 1'b1;
      @(negedge clk);
      go = 1'b0;
      while (busy) @(negedge clk);
      chk({7'h0, statusUpdateFlag}, 8'h01);
      rd(7'h31, 8'h00);
      chk({7'h0, statusUpdateFlag}, 8'h01);
      rd(7'h2e, a[7:0]);
      chk({6'h0, statusUpdateFlag, rateMismatch}, {7'h0, &k[1:0]});
      rd(7'h2f, {2'b00, a[13:8]});
      rd(7'h30, a[23:16]);
   endtask
   task automatic t_reset();
      @(negedge clk);
      reset_n = 1'b0;
      repeat (2) @(negedge clk);
      chk(regReadData, 8'h00);
      chk({6'h0, statusUpdateFlag, rateMismatch}, 8'h00);
      reset_n = 1'b1;
      rd(7'h2f, 8'h00);
      rd(7'h30, 8'h00);
   endtask
   // a block whose start was never flagged must not be published
   task automatic t_nostart();
      a = 24'h5A_C3F1;
      noStart = 1'b1;
      go = 1'b1;
      @(negedge clk);
      go = 1'b0;
      while (busy) @(negedge clk);
      noStart = 1'b0;
      chk({7'h0, statusUpdateFlag}, 8'h00);
      rd(7'h2e, 8'h00);
   endtask
   initial begin
      repeat (16) @(negedge clk);
      reset_n = 1'b1;
      for (int k = 0; k < 4; k++) t_block(k[3:0]);
      t_reset();
      t_nostart();
      t_block(4'h9);
      give_verdict();
   end
   always @(posedge clk) if (++cycles == 20000) begin
      miscompares++;
      give_verdict();
   end
endmodule // scs_chan_status_regs_tb_top
